/* include/omp_defines.vh */
// Register map, field positions and encodings of the operating-mode block
`ifndef OMP_DEFINES_VH
`define OMP_DEFINES_VH

// Register byte offsets
`define OMP_CTRL_OFS        8'h00
`define OMP_STATUS_OFS      8'h04
`define OMP_ROOT_LO_OFS     8'h08
`define OMP_ROOT_HI_OFS     8'h0C
`define OMP_EVENT_OFS       8'h10
`define OMP_ADDR_CFG_OFS    8'h14
`define OMP_ROOT_EFF_LO_OFS 8'h18
`define OMP_ROOT_EFF_HI_OFS 8'h1C
`define OMP_SAVE_INFO_OFS   8'h20
`define OMP_EA_BASE_LO_OFS  8'h24
`define OMP_EA_BASE_HI_OFS  8'h28
`define OMP_EA_IDX_LO_OFS   8'h2C
`define OMP_EA_IDX_HI_OFS   8'h30
`define OMP_EA_DISP_OFS     8'h34
`define OMP_EA_RES_LO_OFS   8'h38
`define OMP_EA_RES_HI_OFS   8'h3C

// Control register fields
`define OMP_CTRL_PE         0
`define OMP_CTRL_PG         1
`define OMP_CTRL_LME        2
`define OMP_CTRL_PAE        3
`define OMP_CTRL_PSE        4
`define OMP_CTRL_VRS        5
`define OMP_CTRL_DISP8      8

// Event register fields (write only, self clearing)
`define OMP_EVT_MGMT_ENTER  0
`define OMP_EVT_MGMT_RETURN 1
`define OMP_EVT_CODE_LOAD   2
`define OMP_EVT_CODE_LONG   3

// Mode encodings
`define OMP_MODE_REAL       3'h0
`define OMP_MODE_PROT       3'h1
`define OMP_MODE_VREAL      3'h2
`define OMP_MODE_COMPAT     3'h3
`define OMP_MODE_LONG64     3'h4
`define OMP_MODE_MGMT       3'h5

// Address widths and table geometry
`define OMP_VA_LONG         7'h40
`define OMP_VA_LEGACY       7'h20
`define OMP_PA_BITS         7'h34
`define OMP_PSE_PDE_PA      7'h28
`define OMP_ENTRY_WIDE      7'h40
`define OMP_ENTRY_NARROW    7'h20
`define OMP_DPT_LONG        10'h200
`define OMP_DPT_LEGACY      10'h004
`define OMP_LEVELS_LONG     3'h4
`define OMP_LEVELS_PAE      3'h3
`define OMP_LEVELS_PLAIN    3'h2

// Root pointer targets
`define OMP_ROOT_TOP_MAP    2'h0
`define OMP_ROOT_DIR_PTR    2'h1
`define OMP_ROOT_PAGE_DIR   2'h2

// Management save area layout facts
`define OMP_SAVE_FMT_WIDE   8'h40
`define OMP_RESTART_BYTES   4'h1

// AHB transfer type bit that marks an active transfer
`define OMP_HTRANS_ACTIVE   1

`endif

/* src/omp_ctrl.v */
// Operating-mode and paging control block with an AHB-Lite register slave
//
// Functional notes
// RQ1: Long mode active: virtual real-address flag never affects the current mode.
// RQ2: Long mode enabled: write setting virtual real-address flag is silently dropped.
// RQ3: Protected enable cannot be cleared while long mode is active.
// RQ4: Reset enters legacy real mode; stays legacy until software activates long.
// RQ5: Management entry from any mode; return restores exactly the interrupted mode.
// RQ6: One 64-bit-capable save format is used whatever mode was left.
// RQ7: Halt-restart and I/O-restart save indicators are one byte each.
// RQ8: Virtual addresses 64 bits in long mode, legacy size otherwise.
// RQ9: Physical addresses up to 52 bits in both long and legacy modes.
// RQ10: Long mode effective address 64-bit, displacements sign-extended; legacy 32-bit.
// RQ11: Paging cannot activate long mode unless address extension is enabled.
// RQ12: Address extension enabled makes every paging entry 64 bits wide.
// RQ13: Long mode ignores size extension; only 4K and 2M pages.
// RQ14: Long mode adds top-level map table; pointer tables hold 512 entries.
// RQ15: Root pointer 64 bits; legacy masks upper half and picks its target.
// RQ16: Four-level walk only in long mode, never in legacy mode.
// RQ17: Legacy with address extension: entries take up to 52 physical bits.
// RQ18: Legacy size extension: 4M directory entry carries 40 physical bits.
// RQ19: With long enabled, paging bit set or clear activates or deactivates long.
// RQ20: Code load with long attribute in compatibility mode enters 64-bit submode.
// RQ21: One encoded current-mode state drives all translation gating; here lma and the extension enables drive it instead.
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "omp_defines.vh"

module omp_ctrl
(
	// Clock, reset, enable
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hce,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire        hready,
	input  wire [31:0] hwdata,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Mode outputs
	output reg  [2:0]  cur_mode,
	output reg         long_mode_active,
	output reg         four_level_walk
);

	// Maps an offset onto the register file
	function is_mapped;
		input [31:0] a;
		begin
			is_mapped = (a[31:6] == 26'h000_0000) && (a[1:0] == 2'h0);
		end
	endfunction

	// Long submodes of the encoded mode state
	function is_long_mode;
		input [2:0] m;
		begin
			is_long_mode = (m == `OMP_MODE_COMPAT) || (m == `OMP_MODE_LONG64);
		end
	endfunction

	// Control state
	reg        prot_enable_reg;
	reg        paging_enable_bit_reg;
	reg        long_mode_enable_reg;
	reg        phys_addr_extension_enable_reg;
	reg        page_size_extension_enable_reg;
	reg        virtual_real_submode_flag_reg;
	reg        disp8_reg;
	reg        code_long_reg;
	reg [63:0] translation_root_pointer_reg;
	reg [2:0]  mode_reg;
	reg [2:0]  saved_mode_reg;
	reg [63:0] ea_base_reg;
	reg [63:0] ea_index_reg;
	reg [31:0] ea_disp_reg;

	// Bus phase state
	reg        wr_pend_reg;
	reg        rd_pend_reg;
	reg        rd_wait_reg;
	reg [7:0]  wr_addr_reg;
	reg [7:0]  rd_addr_reg;

	// Derived control values
	wire       in_mgmt;
	wire       lma;
	wire       wr_ctrl;
	wire       wr_event;
	wire       addr_take;
	reg        pe_next;
	reg        pg_next;
	reg        lme_next;
	reg        pae_next;
	reg        vrs_next;
	reg [2:0]  mode_next;

	// Translation view
	reg [6:0]  va_width;
	reg [6:0]  entry_width;
	reg [6:0]  pde_pa_bits;
	reg [2:0]  walk_levels;
	reg [9:0]  dpt_entries;
	reg [2:0]  page_sizes;
	reg [1:0]  root_target;
	reg [63:0] root_eff;
	reg [63:0] ea_result;
	reg [63:0] disp_ext;
	reg [31:0] rd_mux;

	assign in_mgmt = (mode_reg == `OMP_MODE_MGMT);
	// Long mode is live only with enable, paging, protection and extension
	assign lma = long_mode_enable_reg & paging_enable_bit_reg &
		prot_enable_reg & phys_addr_extension_enable_reg; // [RQ19]
	assign wr_ctrl = wr_pend_reg && (wr_addr_reg == `OMP_CTRL_OFS);
	assign wr_event = wr_pend_reg && (wr_addr_reg == `OMP_EVENT_OFS);
	assign addr_take = hsel && hready && htrans[`OMP_HTRANS_ACTIVE];

	// Filtered control write
	always @*
	begin
		pe_next = hwdata[`OMP_CTRL_PE];
		lme_next = hwdata[`OMP_CTRL_LME];
		pae_next = hwdata[`OMP_CTRL_PAE];
		pg_next = hwdata[`OMP_CTRL_PG];
		vrs_next = hwdata[`OMP_CTRL_VRS];
		if (lma)
		begin
			pe_next = 1'b1; // [RQ3]
			pae_next = 1'b1; // [RQ11]
			if (pg_next)
				lme_next = 1'b1;
		end
		if (pg_next && lme_next && !pae_next)
			pg_next = 1'b0; // [RQ11]
		if (long_mode_enable_reg || lme_next)
			vrs_next = vrs_next & virtual_real_submode_flag_reg; // [RQ2]
	end

	// Current mode from the control state
	always @*
	begin
		mode_next = mode_reg;
		if (wr_event && hwdata[`OMP_EVT_MGMT_ENTER] && !in_mgmt)
			mode_next = `OMP_MODE_MGMT; // [RQ5]
		else if (wr_event && hwdata[`OMP_EVT_MGMT_RETURN] && in_mgmt)
			mode_next = saved_mode_reg; // [RQ5]
		else if (!in_mgmt)
		begin
			if (lma)
				mode_next = code_long_reg ? `OMP_MODE_LONG64 : `OMP_MODE_COMPAT; // [RQ1] [RQ20]
			else if (!prot_enable_reg)
				mode_next = `OMP_MODE_REAL;
			else if (virtual_real_submode_flag_reg)
				mode_next = `OMP_MODE_VREAL;
			else
				mode_next = `OMP_MODE_PROT;
		end
	end

	// Translation gating from lma and the extension enables
	always @*
	begin
		va_width = lma ? `OMP_VA_LONG : `OMP_VA_LEGACY; // [RQ8]
		entry_width = phys_addr_extension_enable_reg ?
			`OMP_ENTRY_WIDE : `OMP_ENTRY_NARROW; // [RQ12]
		pde_pa_bits = 7'h00;
		dpt_entries = 10'h000;
		root_target = `OMP_ROOT_PAGE_DIR;
		root_eff = {32'h0000_0000, translation_root_pointer_reg[31:0]}; // [RQ15]
		if (lma)
		begin
			walk_levels = `OMP_LEVELS_LONG; // [RQ16]
			dpt_entries = `OMP_DPT_LONG; // [RQ14]
			page_sizes = 3'h3; // [RQ13]
			root_target = `OMP_ROOT_TOP_MAP;
			root_eff = translation_root_pointer_reg; // [RQ15]
			pde_pa_bits = `OMP_PA_BITS;
		end
		else if (phys_addr_extension_enable_reg)
		begin
			walk_levels = `OMP_LEVELS_PAE;
			dpt_entries = `OMP_DPT_LEGACY;
			page_sizes = 3'h3;
			root_target = `OMP_ROOT_DIR_PTR;
			pde_pa_bits = `OMP_PA_BITS; // [RQ17]
		end
		else if (page_size_extension_enable_reg)
		begin
			walk_levels = `OMP_LEVELS_PLAIN;
			page_sizes = 3'h5;
			pde_pa_bits = `OMP_PSE_PDE_PA; // [RQ18]
		end
		else
		begin
			walk_levels = `OMP_LEVELS_PLAIN;
			page_sizes = 3'h1;
		end
	end

	// Effective address calculation
	always @*
	begin
		if (disp8_reg)
			disp_ext = {{56{ea_disp_reg[7]}}, ea_disp_reg[7:0]};
		else
			disp_ext = {{32{ea_disp_reg[31]}}, ea_disp_reg};
		if (lma)
			ea_result = ea_base_reg + ea_index_reg + disp_ext; // [RQ10]
		else
			ea_result = {32'h0000_0000,
				ea_base_reg[31:0] + ea_index_reg[31:0] + disp_ext[31:0]}; // [RQ10]
	end

	// Read data selection
	always @*
	begin
		case (rd_addr_reg)
			`OMP_CTRL_OFS:
				rd_mux = {23'h00_0000, disp8_reg, 2'h0,
					virtual_real_submode_flag_reg, page_size_extension_enable_reg,
					phys_addr_extension_enable_reg, long_mode_enable_reg,
					paging_enable_bit_reg, prot_enable_reg};
			`OMP_STATUS_OFS:
				rd_mux = {10'h000, dpt_entries, 2'h0, root_target, 1'b0, code_long_reg,
					lma & (mode_reg != `OMP_MODE_MGMT), in_mgmt, 1'b0, mode_reg}; // [RQ14]
			`OMP_ROOT_LO_OFS:
				rd_mux = translation_root_pointer_reg[31:0];
			`OMP_ROOT_HI_OFS:
				rd_mux = translation_root_pointer_reg[63:32];
			`OMP_ADDR_CFG_OFS:
				rd_mux = {1'b0, page_sizes, 1'b0, walk_levels, 1'b0, entry_width,
					1'b0, `OMP_PA_BITS, 1'b0, va_width}; // [RQ9]
			`OMP_ROOT_EFF_LO_OFS:
				rd_mux = root_eff[31:0];
			`OMP_ROOT_EFF_HI_OFS:
				rd_mux = root_eff[63:32];
			`OMP_SAVE_INFO_OFS:
				rd_mux = {5'h00, pde_pa_bits, 1'b0, saved_mode_reg,
					`OMP_RESTART_BYTES, `OMP_RESTART_BYTES,
					`OMP_SAVE_FMT_WIDE}; // [RQ6] [RQ7]
			`OMP_EA_BASE_LO_OFS:
				rd_mux = ea_base_reg[31:0];
			`OMP_EA_BASE_HI_OFS:
				rd_mux = ea_base_reg[63:32];
			`OMP_EA_IDX_LO_OFS:
				rd_mux = ea_index_reg[31:0];
			`OMP_EA_IDX_HI_OFS:
				rd_mux = ea_index_reg[63:32];
			`OMP_EA_DISP_OFS:
				rd_mux = ea_disp_reg;
			`OMP_EA_RES_LO_OFS:
				rd_mux = ea_result[31:0];
			`OMP_EA_RES_HI_OFS:
				rd_mux = ea_result[63:32];
			default:
				rd_mux = 32'h0000_0000;
		endcase
	end

	// Bus phases: writes without wait, reads with two wait states
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			rd_addr_reg <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end
		else if (hce)
		begin
			wr_pend_reg <= 1'b0;
			if (addr_take && hwrite)
			begin
				wr_pend_reg <= is_mapped(haddr);
				wr_addr_reg <= haddr[7:0];
			end
			else if (addr_take)
			begin
				rd_pend_reg <= 1'b1;
				rd_wait_reg <= 1'b1;
				rd_addr_reg <= is_mapped(haddr) ? haddr[7:0] : 8'hFF;
				hreadyout <= 1'b0;
			end
			else if (rd_wait_reg)
				rd_wait_reg <= 1'b0;
			else if (rd_pend_reg)
			begin
				rd_pend_reg <= 1'b0;
				hrdata <= rd_mux;
				hreadyout <= 1'b1;
			end
		end
	end

	// Control, mode and data registers
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			prot_enable_reg <= 1'b0; // [RQ4]
			paging_enable_bit_reg <= 1'b0;
			long_mode_enable_reg <= 1'b0;
			phys_addr_extension_enable_reg <= 1'b0;
			page_size_extension_enable_reg <= 1'b0;
			virtual_real_submode_flag_reg <= 1'b0;
			disp8_reg <= 1'b0;
			code_long_reg <= 1'b0;
			translation_root_pointer_reg <= 64'h0000_0000_0000_0000;
			mode_reg <= `OMP_MODE_REAL; // [RQ4]
			saved_mode_reg <= `OMP_MODE_REAL;
			ea_base_reg <= 64'h0000_0000_0000_0000;
			ea_index_reg <= 64'h0000_0000_0000_0000;
			ea_disp_reg <= 32'h0000_0000;
		end
		else if (hce)
		begin
			mode_reg <= mode_next; // [RQ21]
			if (wr_event && hwdata[`OMP_EVT_MGMT_ENTER] && !in_mgmt)
				saved_mode_reg <= mode_reg; // [RQ5]
			// Control is frozen in management mode so return is exact
			if (wr_ctrl && !in_mgmt)
			begin
				prot_enable_reg <= pe_next;
				paging_enable_bit_reg <= pg_next;
				long_mode_enable_reg <= lme_next;
				phys_addr_extension_enable_reg <= pae_next;
				page_size_extension_enable_reg <= hwdata[`OMP_CTRL_PSE];
				virtual_real_submode_flag_reg <= vrs_next;
				disp8_reg <= hwdata[`OMP_CTRL_DISP8];
			end
			if (wr_event && hwdata[`OMP_EVT_CODE_LOAD] && !in_mgmt)
				code_long_reg <= hwdata[`OMP_EVT_CODE_LONG] & lma; // [RQ20]
			else if (!lma)
				code_long_reg <= 1'b0;
			if (wr_pend_reg)
			begin
				case (wr_addr_reg)
					`OMP_ROOT_LO_OFS:
						translation_root_pointer_reg[31:0] <= hwdata;
					`OMP_ROOT_HI_OFS:
						translation_root_pointer_reg[63:32] <= hwdata;
					`OMP_EA_BASE_LO_OFS:
						ea_base_reg[31:0] <= hwdata;
					`OMP_EA_BASE_HI_OFS:
						ea_base_reg[63:32] <= hwdata;
					`OMP_EA_IDX_LO_OFS:
						ea_index_reg[31:0] <= hwdata;
					`OMP_EA_IDX_HI_OFS:
						ea_index_reg[63:32] <= hwdata;
					`OMP_EA_DISP_OFS:
						ea_disp_reg <= hwdata;
					default:
						ea_disp_reg <= ea_disp_reg;
				endcase
			end
		end
	end

	// Registered mode outputs
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cur_mode <= `OMP_MODE_REAL;
			long_mode_active <= 1'b0;
			four_level_walk <= 1'b0;
		end
		else if (hce)
		begin
			cur_mode <= mode_reg;
			// Taken from the mode state so all three ports change on one edge
			long_mode_active <= is_long_mode(mode_reg); // [RQ21]
			four_level_walk <= is_long_mode(mode_reg); // [RQ16]
		end
	end

endmodule // omp_ctrl

/* tb/omp_ctrl_chk.sv */
// Concurrent checks on the ports of the operating-mode control block
`timescale 1ns/10ps
`include "omp_defines.vh"

module omp_ctrl_chk
(
	// Clock and reset
	input wire       hclk,
	input wire       hresetn,
	// Bus request side
	input wire       hce,
	input wire       hsel,
	input wire [1:0] htrans,
	input wire       hwrite,
	input wire       hready,
	// Watched outputs
	input wire       hreadyout,
	input wire       hresp,
	input wire [2:0] cur_mode,
	input wire       long_mode_active,
	input wire       four_level_walk
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// A transfer is taken at this edge
	wire take = hce && hsel && hready && htrans[1];

	chk_bus_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
		else $error("read wait states wrong");
	chk_write_zero: assert property (take && hwrite |=> hreadyout)
		else $error("write got wait state");
	chk_walk_long: assert property (four_level_walk == long_mode_active)
		else $error("four level walk outside long mode");
	chk_long_prot: assert property (long_mode_active |-> cur_mode != `OMP_MODE_REAL)
		else $error("real mode while long active");
	chk_long_novreal: assert property (long_mode_active |-> cur_mode != `OMP_MODE_VREAL)
		else $error("virtual real mode while long active");
	chk_submode_long: assert property ((cur_mode == `OMP_MODE_COMPAT ||
		cur_mode == `OMP_MODE_LONG64) |-> long_mode_active)
		else $error("long submode without long active");
	chk_mode_legal: assert property (cur_mode <= `OMP_MODE_MGMT)
		else $error("mode code out of range");
	chk_reset_real: assert property ($rose(hresetn) |-> cur_mode == 3'h0 && !long_mode_active)
		else $error("not real mode after reset");
	chk_freeze_hold: assert property (!hce |=> $stable(cur_mode) && $stable(long_mode_active))
		else $error("mode ports moved while clock enable low");
endmodule // omp_ctrl_chk

bind omp_ctrl omp_ctrl_chk i_omp_ctrl_chk
(
	.hclk             (hclk),
	.hresetn          (hresetn),
	.hce              (hce),
	.hsel             (hsel),
	.htrans           (htrans),
	.hwrite           (hwrite),
	.hready           (hready),
	.hreadyout        (hreadyout),
	.hresp            (hresp),
	.cur_mode         (cur_mode),
	.long_mode_active (long_mode_active),
	.four_level_walk  (four_level_walk)
);

/* tb/testbench.sv */
// Self-checking testbench for the operating-mode control block
`timescale 1ns/10ps
`include "omp_defines.vh"

module testbench;
	logic        hclk, hresetn, hwrite, rp, hce;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, rs, bl, bh;
	logic [31:0] eq[$], mq[$];
	wire  [31:0] hrdata;
	wire  [2:0]  cur_mode;
	wire         hreadyout, hresp, lma, flw;
	int          miscompares, checks, cyc;

	// Device under test
	omp_ctrl i_omp_ctrl
	(
		.hclk             (hclk),
		.hresetn          (hresetn),
		.hce              (hce),
		.hsel             (1'b1),
		.haddr            (haddr),
		.htrans           (htrans),
		.hwrite           (hwrite),
		.hsize            (3'b010),
		.hready           (hreadyout),
		.hwdata           (hwdata),
		.hrdata           (hrdata),
		.hreadyout        (hreadyout),
		.hresp            (hresp),
		.cur_mode         (cur_mode),
		.long_mode_active (lma),
		.four_level_walk  (flw)
	);

	// Clock of 10 ns
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	task automatic print_verdict();
		if (miscompares == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] v, input logic [31:0] e);
		checks++;
		if (v !== e)
		begin
			$display("wrong value at %0t: read %h, expected %h", $time, v, e);
			miscompares++;
		end
	endtask

	// One single transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		htrans <= 2'b10;
		hwrite <= w;
		haddr  <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	// Read noting the expected value under a mask
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
		eq.push_back(e);
		mq.push_back(m);
		bus(1'b0, a, 32'h0000_0000);
	endtask

	// Effective address from random operands
	task automatic ea_chk(input logic lng);
		logic [31:0] v[5];
		logic [63:0] s;
		for (int i = 0; i < 5; i++)
		begin
			v[i] = rnd();
			wr(32'(`OMP_EA_BASE_LO_OFS + 4 * i), v[i]);
		end
		s = {v[1], v[0]} + {v[3], v[2]} + {{32{v[4][31]}}, v[4]};
		rd(`OMP_EA_RES_LO_OFS, s[31:0], 32'hffff_ffff);
		rd(`OMP_EA_RES_HI_OFS, lng ? s[63:32] : 32'h0000_0000, 32'hffff_ffff);
	endtask

	// Compares read data with the oldest note
	always @(posedge hclk)
	begin
		if (rp && hreadyout)
		begin
			chk(hrdata & mq.pop_front(), eq.pop_front());
			rp = 1'b0;
		end
		if (htrans[1] && hreadyout && !hwrite)
			rp = 1'b1;
	end

	// Cuts a hang short
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			miscompares++;
			print_verdict();
		end
	end

	// Main sequence
	initial
	begin
		{hresetn, hwrite, htrans, haddr, hwdata, rp} = '0;
		hce = 1'b1;
		rs = 32'h0000_000c;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rd(`OMP_STATUS_OFS, 32'h0000_0000, 32'h0000_0037);
		rd(`OMP_ADDR_CFG_OFS, 32'h0220_3420, 32'h077f_7f7f);
		wr(`OMP_CTRL_OFS, 32'h0000_0007);
		rd(`OMP_STATUS_OFS, 32'h0000_0001, 32'h0000_0027);
		wr(`OMP_CTRL_OFS, 32'h0000_003f);
		rd(`OMP_CTRL_OFS, 32'h0000_001f, 32'h0000_003f);
		rd(`OMP_STATUS_OFS, 32'h0020_0023, 32'h003f_f327);
		rd(`OMP_ADDR_CFG_OFS, 32'h3440_3440, 32'h777f_7f7f);
		wr(`OMP_CTRL_OFS, 32'h0000_001e);
		rd(`OMP_CTRL_OFS, 32'h0000_001f, 32'h0000_003f);
		bl = rnd();
		bh = rnd();
		wr(`OMP_ROOT_LO_OFS, bl);
		wr(`OMP_ROOT_HI_OFS, bh);
		rd(`OMP_ROOT_EFF_LO_OFS, bl, 32'hffff_ffff);
		rd(`OMP_ROOT_EFF_HI_OFS, bh, 32'hffff_ffff);
		ea_chk(1'b1);
		// A write while the clock enable is low must leave long mode untouched
		hce <= 1'b0;
		wr(`OMP_CTRL_OFS, 32'h0000_0000);
		hce <= 1'b1;
		rd(`OMP_CTRL_OFS, 32'h0000_001f, 32'h0000_003f);
		wr(`OMP_EVENT_OFS, 32'h0000_000c);
		rd(`OMP_STATUS_OFS, 32'h0000_0064, 32'h0000_007f);
		chk(32'(cur_mode), 32'h0000_0004);
		chk(32'({lma, flw}), 32'h0000_0003);
		wr(`OMP_EVENT_OFS, 32'h0000_0001);
		rd(`OMP_STATUS_OFS, 32'h0000_0015, 32'h0000_0017);
		chk(32'(cur_mode), 32'h0000_0005);
		rd(`OMP_SAVE_INFO_OFS, 32'h0004_1140, 32'h0007_ffff);
		wr(`OMP_CTRL_OFS, 32'h0000_0000);
		wr(`OMP_EVENT_OFS, 32'h0000_0002);
		rd(`OMP_STATUS_OFS, 32'h0000_0024, 32'h0000_0037);
		wr(`OMP_CTRL_OFS, 32'h0000_000d);
		rd(`OMP_STATUS_OFS, 32'h0000_4101, 32'h003f_f327);
		chk(32'(cur_mode), 32'h0000_0001);
		chk(32'({lma, flw}), 32'h0000_0000);
		rd(`OMP_SAVE_INFO_OFS, 32'h0340_0000, 32'h07f0_0000);
		rd(`OMP_ROOT_EFF_HI_OFS, 32'h0000_0000, 32'hffff_ffff);
		rd(`OMP_ADDR_CFG_OFS, 32'h0340_3420, 32'h077f_7f7f);
		ea_chk(1'b0);
		wr(`OMP_CTRL_OFS, 32'h0000_0013);
		wr(`OMP_CTRL_OFS, 32'h0000_0033);
		rd(`OMP_STATUS_OFS, 32'h0000_0202, 32'h0000_0337);
		rd(`OMP_ADDR_CFG_OFS, 32'h4000_0000, 32'h4000_0000);
		rd(`OMP_SAVE_INFO_OFS, 32'h0280_0000, 32'h07f0_0000);
		rd(32'h0000_0040, 32'h0000_0000, 32'hffff_ffff);
		rd(32'h0000_0002, 32'h0000_0000, 32'hffff_ffff);
		repeat (2) @(posedge hclk);
		print_verdict();
	end
endmodule // testbench
